// *** drt_pkg.sv ***
// Shared constants and types of the D-PHY re-timer control block
package drt_pkg;

	// ****************************************************************
	// Register indices; byte address is four times the index
	// ****************************************************************
	localparam logic [7:0] IDX_HS_CTRL = 8'h0E;
	localparam logic [7:0] IDX_TO_LOW = 8'h10;
	localparam logic [7:0] IDX_TO_HIGH = 8'h11;
	localparam logic [7:0] IDX_STATUS = 8'h12;
	localparam logic [7:0] IDX_COUNT = 8'h13;

	// ****************************************************************
	// Bus constants
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int SWING_LSB = 4;
	localparam int PRE_LSB = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_REV_BIT = 1;
	localparam int ST_TMO_BIT = 2;
	localparam logic [7:0] HS_CTRL_RESET = 8'h00;
	localparam logic [7:0] TO_RESET = 8'hFF;
	localparam logic [1:0] CFG_SETTLE_CYC = 2'h3;

	// ****************************************************************
	// Field codes and sampled pin levels
	// ****************************************************************
	localparam logic [1:0] SWING_180 = 2'h0;
	localparam logic [1:0] SWING_200 = 2'h1;
	localparam logic [1:0] SWING_220 = 2'h2;
	localparam logic [1:0] PRE_1P5 = 2'h0;
	localparam logic [1:0] PRE_0 = 2'h1;
	localparam logic [1:0] PRE_2P5 = 2'h2;
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;

	// ****************************************************************
	// Synchroniser width and turnaround states
	// ****************************************************************
	localparam int SYNC_W = 13;

	typedef enum logic [1:0] {
		BTA_IDLE,
		BTA_WAIT,
		BTA_REV
	} drt_bta_t;

	// Pin level 3 counts as high
	function automatic logic [1:0] swing_from_pins(logic [1:0] c0,
			logic [1:0] c1);
		logic c0_hi;
		logic c1_hi;
		c0_hi = (c0 == LVL_HIGH) || (c0 == 2'h3);
		c1_hi = (c1 == LVL_HIGH) || (c1 == 2'h3);
		if (c0_hi || ((c0 == LVL_LOW) && c1_hi)) begin
			return SWING_220;
		end
		return SWING_200;
	endfunction : swing_from_pins

	function automatic logic [1:0] pre_from_pin(logic [1:0] c1);
		if ((c1 == LVL_HIGH) || (c1 == 2'h3)) begin
			return PRE_2P5;
		end
		return PRE_0;
	endfunction : pre_from_pin

endpackage : drt_pkg

// *** drt_sync.sv ***
// Two-stage synchroniser for a vector of unrelated levels
module drt_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} drt_sync_st_t;

	drt_sync_st_t s_r;
	drt_sync_st_t s_nxt;

	always_comb begin
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.s2;

endmodule : drt_sync

// *** drt_top.sv ***
// Register bank, turnaround timer and lane forwarding of the re-timer

// Operation
// - Swing field at bits 5:4: 00 180 mV, 01 200 mV, 1X 220 mV.
// - Swing field loads from both sampled config pins, then software may write.
// - Pre-emphasis field at bits 1:0: 00 1.5 dB, 01 0 dB, 1X 2.5 dB.
// - Pre-emphasis loads from config pin one: low/mid gives 01, high gives 1X.
// - Timeout low byte at index 0x10, read-write, resets to 0xFF.
// - Timeout high byte at index 0x11, read-write, resets to 0xFF.
// - Turnaround request detected while idle starts the timer from its configured value.
// - Timer stops once the far party acknowledges the turnaround.
// - Timer expiry before acknowledge abandons the turnaround.
// - Timer counts low-power transmit clock rising edges only.
// - Four data lanes and one clock lane are forwarded.
// - Only data lane 0 carries reverse back-channel traffic.
// - Reduced lane counts such as one or three lanes work.
// - Lane polarity is never inverted.
// - Camera use accepts any data lane assignment.
module drt_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [drt_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [drt_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Configuration pins, level codes
	input wire logic [1:0] config_pin_zero,
	input wire logic [1:0] config_pin_one,
	// Turnaround link signals
	input wire logic low_power_transmit_clock,
	input wire logic bta_request,
	input wire logic bta_acknowledge,
	// Source side lanes
	input wire logic [3:0] src_lane_in,
	input wire logic src_clk_lane_in,
	output logic src_lane0_out,
	output logic src_lane0_oe,
	// Sink side lanes
	output logic [3:0] snk_lane_out,
	output logic snk_lane0_oe,
	input wire logic snk_lane0_in,
	output logic snk_clk_lane_out,
	// Analog settings
	output logic [1:0] hs_swing_level,
	output logic [1:0] hs_preemphasis_level
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_held;
		logic [drt_pkg::ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] swing;
		logic [1:0] pre;
		logic [7:0] to_lo;
		logic [7:0] to_hi;
		logic [1:0] cfg_cnt;
		logic cfg_done;
		drt_pkg::drt_bta_t st;
		logic [15:0] count;
		logic req_prev;
		logic lp_clk_prev;
		logic timeout_seen;
		logic [3:0] lanes;
		logic clk_lane;
		logic snk_oe;
		logic src_oe;
		logic src_out;
	} drt_state_t;

	drt_state_t s_r;
	drt_state_t s_nxt;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [drt_pkg::SYNC_W-1:0] pins_raw;
	logic [drt_pkg::SYNC_W-1:0] pins_q;
	logic [1:0] pin_zero_q;
	logic [1:0] pin_one_q;
	logic lp_clk_q;
	logic req_q;
	logic ack_q;
	logic [3:0] lanes_q;
	logic clk_lane_q;
	logic snk_l0_q;

	assign pins_raw = {config_pin_zero, config_pin_one,
		low_power_transmit_clock, bta_request, bta_acknowledge,
		src_lane_in, src_clk_lane_in, snk_lane0_in};

	drt_sync #(
		.WIDTH(drt_pkg::SYNC_W)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(pins_raw),
		.q(pins_q)
	);

	assign {pin_zero_q, pin_one_q, lp_clk_q, req_q, ack_q, lanes_q,
		clk_lane_q, snk_l0_q} = pins_q;

	// ****************************************************************
	// Next state
	// ****************************************************************
	logic do_wr;
	logic do_rd;
	logic req_rise;
	logic lp_clk_edge;
	logic tmo_set;
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;

	always_comb begin
		s_nxt = s_r;
		tmo_set = 1'b0;
		req_rise = req_q && !s_r.req_prev;
		lp_clk_edge = lp_clk_q && !s_r.lp_clk_prev;
		wr_idx = s_r.aw_addr[drt_pkg::ADDR_W-1:2];
		rd_idx = araddr[drt_pkg::ADDR_W-1:2];
		do_wr = s_r.aw_held && s_r.w_held && !s_r.bvalid;
		do_rd = arvalid && s_r.arready;

		// Write channels, taken in either order
		if (awvalid && s_r.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_addr = awaddr;
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.w_data = wdata[7:0];
			s_nxt.w_strb0 = wstrb[0];
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (do_wr) begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = drt_pkg::RESP_OKAY;
			unique case (wr_idx)
				drt_pkg::IDX_HS_CTRL[5:0]: begin
					if (s_r.w_strb0) begin
						s_nxt.swing = s_r.w_data[drt_pkg::SWING_LSB+:2];
						s_nxt.pre = s_r.w_data[drt_pkg::PRE_LSB+:2];
					end
				end
				drt_pkg::IDX_TO_LOW[5:0]: begin
					if (s_r.w_strb0) begin
						s_nxt.to_lo = s_r.w_data;
					end
				end
				drt_pkg::IDX_TO_HIGH[5:0]: begin
					if (s_r.w_strb0) begin
						s_nxt.to_hi = s_r.w_data;
					end
				end
				drt_pkg::IDX_STATUS[5:0]: begin
					if (s_r.w_strb0 && s_r.w_data[drt_pkg::ST_TMO_BIT]) begin
						s_nxt.timeout_seen = 1'b0;
					end
				end
				drt_pkg::IDX_COUNT[5:0]: begin
				end
				default: begin
					s_nxt.bresp = drt_pkg::RESP_DECERR;
				end
			endcase
		end
		s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;

		// Read channel
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (do_rd) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = drt_pkg::RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			unique case (rd_idx)
				drt_pkg::IDX_HS_CTRL[5:0]: begin
					s_nxt.rdata[drt_pkg::SWING_LSB+:2] = s_r.swing;
					s_nxt.rdata[drt_pkg::PRE_LSB+:2] = s_r.pre;
				end
				drt_pkg::IDX_TO_LOW[5:0]: begin
					s_nxt.rdata[7:0] = s_r.to_lo;
				end
				drt_pkg::IDX_TO_HIGH[5:0]: begin
					s_nxt.rdata[7:0] = s_r.to_hi;
				end
				drt_pkg::IDX_STATUS[5:0]: begin
					s_nxt.rdata[drt_pkg::ST_BUSY_BIT] =
						(s_r.st != drt_pkg::BTA_IDLE);
					s_nxt.rdata[drt_pkg::ST_REV_BIT] =
						(s_r.st == drt_pkg::BTA_REV);
					s_nxt.rdata[drt_pkg::ST_TMO_BIT] = s_r.timeout_seen;
				end
				drt_pkg::IDX_COUNT[5:0]: begin
					s_nxt.rdata[15:0] = s_r.count;
				end
				default: begin
					s_nxt.rresp = drt_pkg::RESP_DECERR;
				end
			endcase
		end
		s_nxt.arready = !s_nxt.rvalid;

		// Strap capture once the synchronisers hold settled pin levels
		if (!s_r.cfg_done) begin
			if (s_r.cfg_cnt == 2'h0) begin
				s_nxt.swing = drt_pkg::swing_from_pins(pin_zero_q,
					pin_one_q);
				s_nxt.pre = drt_pkg::pre_from_pin(pin_one_q);
				s_nxt.cfg_done = 1'b1;
			end else begin
				s_nxt.cfg_cnt = s_r.cfg_cnt - 2'h1;
			end
		end

		// Turnaround timer
		s_nxt.req_prev = req_q;
		s_nxt.lp_clk_prev = lp_clk_q;
		unique case (s_r.st)
			drt_pkg::BTA_IDLE: begin
				if (req_rise) begin
					s_nxt.count = {s_r.to_hi, s_r.to_lo};
					s_nxt.st = drt_pkg::BTA_WAIT;
				end
			end
			drt_pkg::BTA_WAIT: begin
				if (ack_q) begin
					s_nxt.st = drt_pkg::BTA_REV;
				end else if (lp_clk_edge) begin
					if (s_r.count == 16'h0000) begin
						s_nxt.st = drt_pkg::BTA_IDLE;
						tmo_set = 1'b1;
					end else begin
						s_nxt.count = s_r.count - 16'h0001;
					end
				end
			end
			drt_pkg::BTA_REV: begin
				if (!ack_q) begin
					s_nxt.st = drt_pkg::BTA_IDLE;
				end
			end
			default: begin
				s_nxt.st = drt_pkg::BTA_IDLE;
			end
		endcase
		if (tmo_set) begin
			s_nxt.timeout_seen = 1'b1;
		end

		// Lane forwarding, polarity kept, lane 0 may turn round
		s_nxt.lanes = lanes_q;
		s_nxt.clk_lane = clk_lane_q;
		s_nxt.snk_oe = (s_nxt.st == drt_pkg::BTA_IDLE);
		s_nxt.src_oe = (s_nxt.st == drt_pkg::BTA_REV);
		s_nxt.src_out = snk_l0_q;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.swing <= drt_pkg::HS_CTRL_RESET[drt_pkg::SWING_LSB+:2];
			s_r.pre <= drt_pkg::HS_CTRL_RESET[drt_pkg::PRE_LSB+:2];
			s_r.to_lo <= drt_pkg::TO_RESET;
			s_r.to_hi <= drt_pkg::TO_RESET;
			s_r.cfg_cnt <= drt_pkg::CFG_SETTLE_CYC;
			s_r.st <= drt_pkg::BTA_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign arready = s_r.arready;
	assign rvalid = s_r.rvalid;
	assign rdata = s_r.rdata;
	assign rresp = s_r.rresp;
	assign src_lane0_out = s_r.src_out;
	assign src_lane0_oe = s_r.src_oe;
	assign snk_lane_out = s_r.lanes;
	assign snk_lane0_oe = s_r.snk_oe;
	assign snk_clk_lane_out = s_r.clk_lane;
	assign hs_swing_level = s_r.swing;
	assign hs_preemphasis_level = s_r.pre;

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic hs_wr;
	logic cfg_load;

	assign hs_wr = do_wr && s_r.w_strb0 &&
		(wr_idx == drt_pkg::IDX_HS_CTRL[5:0]);
	assign cfg_load = !s_r.cfg_done && (s_r.cfg_cnt == 2'h0);

	sequence seq_bta_start;
		req_rise && (s_r.st == drt_pkg::BTA_IDLE);
	endsequence

	sequence seq_bta_loaded;
		(s_r.st == drt_pkg::BTA_WAIT) && (s_r.count == {$past(s_r.to_hi),
			$past(s_r.to_lo)});
	endsequence

	a_swing_write: assert property (@(posedge aclk) disable iff (!aresetn)
		hs_wr && !cfg_load |=> hs_swing_level ==
			$past(s_r.w_data[drt_pkg::SWING_LSB+:2]))
		else $error("swing field not written");

	a_swing_strap: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_load |=> hs_swing_level ==
			drt_pkg::swing_from_pins($past(pin_zero_q), $past(pin_one_q)))
		else $error("swing field not loaded from pins");

	a_pre_write: assert property (@(posedge aclk) disable iff (!aresetn)
		hs_wr && !cfg_load |=> hs_preemphasis_level ==
			$past(s_r.w_data[drt_pkg::PRE_LSB+:2]))
		else $error("pre-emphasis field not written");

	a_pre_strap: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_load |=> hs_preemphasis_level ==
			drt_pkg::pre_from_pin($past(pin_one_q)))
		else $error("pre-emphasis field not loaded from pin");

	a_low_reset: assert property (@(posedge aclk)
		$rose(aresetn) |-> s_r.to_lo == drt_pkg::TO_RESET)
		else $error("timeout low byte reset value wrong");

	a_high_reset: assert property (@(posedge aclk)
		$rose(aresetn) |-> s_r.to_hi == drt_pkg::TO_RESET)
		else $error("timeout high byte reset value wrong");

	a_bta_load: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_bta_start |=> seq_bta_loaded)
		else $error("turnaround timer not reloaded");

	a_ack_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st == drt_pkg::BTA_WAIT) && ack_q |=>
			(s_r.st == drt_pkg::BTA_REV) && $stable(s_r.count))
		else $error("acknowledge did not stop timer");

	a_timeout_abort: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st == drt_pkg::BTA_WAIT) && !ack_q && lp_clk_edge &&
			(s_r.count == 16'h0000) |=>
			(s_r.st == drt_pkg::BTA_IDLE) && s_r.timeout_seen ##1 snk_lane0_oe)
		else $error("expired turnaround not abandoned");

	a_lp_clk_count: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st == drt_pkg::BTA_WAIT) && !lp_clk_edge |=> $stable(s_r.count))
		else $error("timer moved without low-power clock edge");

	a_lane_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 snk_lane_out == $past(lanes_q) && snk_clk_lane_out == $past(clk_lane_q))
		else $error("lane not forwarded unchanged");

	a_lane0_only: assert property (@(posedge aclk) disable iff (!aresetn)
		src_lane0_oe |-> !snk_lane0_oe && (s_r.st == drt_pkg::BTA_REV))
		else $error("reverse drive outside back channel");

	a_new_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st == drt_pkg::BTA_WAIT) && !lp_clk_edge && !ack_q && do_wr
			|=> $stable(s_r.count))
		else $error("timeout write disturbed running timer");

endmodule : drt_top

// *** drt_far_model.sv ***
// Far-side model: source and sink controllers around the re-timer link
module drt_far_model (
	// Clock
	input wire logic aclk,
	// Commands from the bench
	input wire logic lp_run,
	input wire logic req_cmd,
	input wire logic ack_cmd,
	input wire logic bc_bit,
	// Re-timer drive of sink lane 0
	input wire logic dev_lane0_oe,
	input wire logic dev_lane0_out,
	// Link signals
	output logic low_power_transmit_clock,
	output logic bta_request,
	output logic bta_acknowledge,
	output logic snk_lane0_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sink_drv;
	initial begin
		low_power_transmit_clock = 1'b0;
		sink_drv = 1'b0;
	end
	// Low-power clock runs only within a frame
	always begin
		#80;
		low_power_transmit_clock = lp_run ? ~low_power_transmit_clock : 1'b0;
	end
	assign bta_request = req_cmd;
	assign bta_acknowledge = ack_cmd;
	// Sink drives back-channel data only while it owns lane 0
	always @(posedge aclk) begin
		sink_drv <= ack_cmd ? bc_bit : ~sink_drv;
	end
	// Wire level of lane 0 from both drivers
	assign snk_lane0_in = dev_lane0_oe ? dev_lane0_out : sink_drv;
endmodule : drt_far_model

// *** test_dphy_retimer_tx_cfg_bta_timer.sv ***
// Self-checking bench of the re-timer registers, timer and lanes
module test_dphy_retimer_tx_cfg_bta_timer;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [3:0] s;
		logic [1:0] br;
		logic [31:0] rd;
		logic [1:0] rr;
		logic [3:0] lv;
	} drt_row_t;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, src_clk_lane_in;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb, src_lane_in, snk_lane_out;
	logic [1:0] bresp, rresp, rsp, config_pin_zero, config_pin_one;
	logic [1:0] hs_swing_level, hs_preemphasis_level;
	logic lp_run, req_cmd, ack_cmd, bc_bit, low_power_transmit_clock;
	logic bta_request, bta_acknowledge, snk_lane0_in, src_lane0_out;
	logic src_lane0_oe, snk_lane0_oe, snk_clk_lane_out;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	drt_row_t rows [8];
	drt_top DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
		.config_pin_zero, .config_pin_one, .low_power_transmit_clock,
		.bta_request, .bta_acknowledge, .src_lane_in, .src_clk_lane_in,
		.src_lane0_out, .src_lane0_oe, .snk_lane_out, .snk_lane0_oe,
		.snk_lane0_in, .snk_clk_lane_out, .hs_swing_level,
		.hs_preemphasis_level);
	drt_far_model far (.aclk, .lp_run, .req_cmd, .ack_cmd, .bc_bit,
		.dev_lane0_oe(snk_lane0_oe), .dev_lane0_out(snk_lane_out[0]),
		.low_power_transmit_clock, .bta_request, .bta_acknowledge,
		.snk_lane0_in);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_resp
	task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bits
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s);
		bit done;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		bready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge aclk);
			if (awready === 1'b1) begin
				awvalid <= 1'b0;
			end
			if (wready === 1'b1) begin
				wvalid <= 1'b0;
			end
			if (bvalid === 1'b1) begin
				done = 1'b1;
				rsp = bresp;
				bready <= 1'b0;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		bit done;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge aclk);
			if (arready === 1'b1) begin
				arvalid <= 1'b0;
			end
			if (rvalid === 1'b1) begin
				done = 1'b1;
				rd = rdata;
				rsp = rresp;
				rready <= 1'b0;
			end
		end
	endtask : axi_rd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a);
		chk_resp(rsp, drt_pkg::RESP_OKAY);
		chk_word(rd, exp);
	endtask : rd_chk
	task automatic strap(input logic [1:0] c0, input logic [1:0] c1,
			input logic [31:0] e, input logic [3:0] lv);
		@(posedge aclk);
		config_pin_zero <= c0;
		config_pin_one <= c1;
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (10) @(posedge aclk);
		rd_chk(8'h38, e);
		rd_chk(8'h40, 32'hFF);
		rd_chk(8'h44, 32'hFF);
		rd_chk(8'h48, 32'h0);
		chk_bits({hs_swing_level, hs_preemphasis_level}, lv);
		$display("test reset strap done");
	endtask : strap
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			$display("BAD t=%0t timeout %h %h", $time, cyc, 5000);
			tally_and_finish;
		end
	end
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		{config_pin_zero, config_pin_one} = 4'h6;
		{lp_run, req_cmd, ack_cmd, bc_bit, src_clk_lane_in} = 5'h00;
		src_lane_in = 4'h0;
		rows[0] = '{8'h38, 32'hCC, 4'h1, 2'h0, 32'h00, 2'h0, 4'h0};
		rows[1] = '{8'h38, 32'h11, 4'h1, 2'h0, 32'h11, 2'h0, 4'h5};
		rows[2] = '{8'h38, 32'h22, 4'h1, 2'h0, 32'h22, 2'h0, 4'hA};
		rows[3] = '{8'h38, 32'hFF, 4'h1, 2'h0, 32'h33, 2'h0, 4'hF};
		rows[4] = '{8'h38, 32'h00, 4'h0, 2'h0, 32'h33, 2'h0, 4'hF};
		rows[5] = '{8'h40, 32'h5A, 4'hF, 2'h0, 32'h5A, 2'h0, 4'hF};
		rows[6] = '{8'h44, 32'h00, 4'hF, 2'h0, 32'h00, 2'h0, 4'hF};
		rows[7] = '{8'h00, 32'h77, 4'hF, 2'h3, 32'h00, 2'h3, 4'hF};
		strap(2'h1, 2'h2, 32'h12, 4'h6);
		foreach (rows[i]) begin
			axi_wr(rows[i].a, rows[i].d, rows[i].s);
			chk_resp(rsp, rows[i].br);
			axi_rd(rows[i].a);
			chk_resp(rsp, rows[i].rr);
			if (rows[i].rr === drt_pkg::RESP_OKAY) begin
				chk_word(rd, rows[i].rd);
			end
			chk_bits({hs_swing_level, hs_preemphasis_level}, rows[i].lv);
		end
		$display("test register rows done");
		strap(2'h0, 2'h2, 32'h22, 4'hA);
		strap(2'h2, 2'h0, 32'h21, 4'h9);
		strap(2'h0, 2'h1, 32'h11, 4'h5);
		foreach (rows[i]) begin
			@(posedge aclk);
			src_lane_in <= rows[i].lv ^ 4'h7;
			src_clk_lane_in <= rows[i].lv[0];
			repeat (5) @(posedge aclk);
			chk_bits(snk_lane_out, rows[i].lv ^ 4'h7);
			chk_bits({3'h0, snk_clk_lane_out}, {3'h0, rows[i].lv[0]});
		end
		$display("test lanes done");
		axi_wr(8'h40, 32'h03, 4'hF);
		axi_wr(8'h44, 32'h00, 4'hF);
		req_cmd <= 1'b1;
		repeat (6) @(posedge aclk);
		chk_bits({3'h0, snk_lane0_oe}, 4'h0);
		rd_chk(8'h4C, 32'h03);
		axi_wr(8'h40, 32'h20, 4'hF);
		lp_run = 1'b1;
		repeat (3) @(posedge low_power_transmit_clock);
		repeat (5) @(posedge aclk);
		chk_bits({3'h0, snk_lane0_oe}, 4'h0);
		@(posedge low_power_transmit_clock);
		lp_run = 1'b0;
		repeat (6) @(posedge aclk);
		chk_bits({3'h0, snk_lane0_oe}, 4'h1);
		rd_chk(8'h48, 32'h04);
		axi_wr(8'h48, 32'h04, 4'hF);
		rd_chk(8'h48, 32'h00);
		req_cmd <= 1'b0;
		$display("test turnaround expiry done");
		repeat (3) @(posedge aclk);
		req_cmd <= 1'b1;
		repeat (6) @(posedge aclk);
		rd_chk(8'h4C, 32'h20);
		lp_run = 1'b1;
		repeat (2) @(posedge low_power_transmit_clock);
		lp_run = 1'b0;
		repeat (8) @(posedge aclk);
		rd_chk(8'h4C, 32'h1E);
		ack_cmd <= 1'b1;
		bc_bit <= 1'b1;
		repeat (6) @(posedge aclk);
		chk_bits({2'h0, src_lane0_oe, src_lane0_out}, 4'h3);
		bc_bit <= 1'b0;
		repeat (6) @(posedge aclk);
		chk_bits({2'h0, src_lane0_oe, src_lane0_out}, 4'h2);
		lp_run = 1'b1;
		repeat (40) @(posedge low_power_transmit_clock);
		lp_run = 1'b0;
		repeat (6) @(posedge aclk);
		rd_chk(8'h4C, 32'h1E);
		axi_rd(8'h48);
		chk_word(rd, 32'h03);
		ack_cmd <= 1'b0;
		repeat (6) @(posedge aclk);
		chk_bits({2'h0, src_lane0_oe, snk_lane0_oe}, 4'h1);
		req_cmd <= 1'b0;
		$display("test turnaround acknowledge done");
		tally_and_finish;
	end
endmodule : test_dphy_retimer_tx_cfg_bta_timer
